// [src/uart_async_receiver_recovery.sv]
/*
  Asynchronous receiver: clock and data recovery, stop check, buffer and flush.
  Assumes i_sample_tick pulses once per sample period (16x or 8x baud) from a
  baud generator on the same clock, and that the serial pin is asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module uart_async_receiver_recovery
  import uart_rx_pkg::*;
(
  input wire logic i_clock,                    // 40 MHz system clock
  input wire logic i_rstn,                     // Async reset, active low
  input wire logic i_receiver_enable_bit,      // Receiver enable
  input wire logic i_double_speed_select,      // 8 samples per bit when high
  input wire logic i_sample_tick,              // One pulse per sample period
  input wire logic i_serial_input_pin,         // Asynchronous serial line
  output logic o_pin_override,                 // Receiver owns the pin
  input wire logic i_data_read,                // Read strobe of the data location
  output logic o_receive_complete,             // Unread character present
  output uart_rx_pkg::rx_entry_t o_data_buffer_location, // Head character and flags
  output logic o_frame_active                  // Frame in progress
);
  localparam int EW = $bits(rx_entry_t);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchroniser
  logic sync1_q, sync2_q, line_prev_q;
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= i_serial_input_pin;
      sync2_q <= sync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Recovery state
  rx_state_t state_q, state_d;
  logic [3:0] sample_q, bitn_q;
  logic [2:0] votes_q;
  logic [DATA_BITS-1:0] shift_q;
  logic pending_q, pend_ovr_q, ovr_flag_q;
  logic fifo_in_ready, fifo_out_valid;
  rx_entry_t fifo_in, fifo_out;

  wire enabled = i_receiver_enable_bit;
  wire [3:0] last_sample = i_double_speed_select ? SAMPLES_DOUBLE : SAMPLES_NORMAL;
  wire [3:0] vote_first = i_double_speed_select ? VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL;
  wire [3:0] vote_last = vote_first + 4'h2;
  wire in_vote = (sample_q >= vote_first) && (sample_q <= vote_last);
  wire [2:0] votes_now = {votes_q[1:0], sync2_q};
  wire majority = (votes_now[0] & votes_now[1]) | (votes_now[1] & votes_now[2]) |
                  (votes_now[0] & votes_now[2]);
  wire vote_done = i_sample_tick && (sample_q == vote_last);
  wire falling = i_sample_tick && line_prev_q && !sync2_q;
  wire stop_done = (state_q == ST_BITS) && vote_done && (bitn_q == BIT_COUNT_STOP);
  wire start_ok = (state_q == ST_START) && vote_done && !majority;
  wire start_noise = (state_q == ST_START) && vote_done && majority;
  wire new_frame = (state_q == ST_IDLE) && falling;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (falling) state_d = ST_START;
      ST_START: begin
        if (start_noise) state_d = ST_IDLE;
        else if (start_ok) state_d = ST_BITS;
      end
      ST_BITS: if (stop_done) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
    if (!enabled) state_d = ST_IDLE;
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= ST_IDLE;
      line_prev_q <= 1'b1;
    end else begin
      state_q <= state_d;
      if (i_sample_tick || !enabled) line_prev_q <= enabled ? sync2_q : 1'b1;
    end
  end

  // Sample counter: sample 1 is the first low sample; restarts per start bit
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      sample_q <= 4'h0;
      bitn_q <= 4'h0;
      votes_q <= 3'h0;
    end else if (!enabled || state_q == ST_IDLE) begin
      sample_q <= 4'h1;
      bitn_q <= 4'h0;
      votes_q <= 3'h0;
    end else if (i_sample_tick) begin
      if (in_vote) votes_q <= votes_now;
      if (sample_q == last_sample) begin
        sample_q <= 4'h0;
        bitn_q <= bitn_q + 4'h1;
      end else begin
        sample_q <= sample_q + 4'h1;
      end
    end
  end

  // Data bits shift in LSB first
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      shift_q <= '0;
    end else if (state_q == ST_BITS && vote_done && bitn_q != BIT_COUNT_STOP) begin
      shift_q <= {majority, shift_q[DATA_BITS-1:1]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hand-off to the buffer, overrun tracking
  // A finished frame waits here (the pending slot) while the buffer is full.
  logic pend_fe_q;
  logic [DATA_BITS-1:0] pend_data_q;
  wire push = pending_q && fifo_in_ready;
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      pending_q <= 1'b0;
      pend_fe_q <= 1'b0;
      pend_data_q <= '0;
      pend_ovr_q <= 1'b0;
      ovr_flag_q <= 1'b0;
    end else if (!enabled) begin
      pending_q <= 1'b0;
      ovr_flag_q <= 1'b0;
      pend_ovr_q <= 1'b0;
    end else begin
      if (stop_done && !(pending_q && !push)) begin
        pending_q <= 1'b1;
        pend_fe_q <= ~majority;
        pend_data_q <= shift_q;
        pend_ovr_q <= ovr_flag_q;
      end else if (push) begin
        pending_q <= 1'b0;
      end
      // Lost frames are counted against the next stored character
      if (new_frame && pending_q && !fifo_in_ready) ovr_flag_q <= 1'b1;
      else if (stop_done && !(pending_q && !push)) ovr_flag_q <= 1'b0;
    end
  end

  assign fifo_in = '{overrun: pend_ovr_q, frame_error: pend_fe_q, data: pend_data_q};

  // Four-entry FIFO models the two-character buffer plus margin; full means
  // no more room; with a frame pending and a new start, that is the overrun condition here.
  rx_fifo #(.WIDTH(EW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_flush(!enabled),
    .i_in_valid(push),
    .o_in_ready(fifo_in_ready),
    .i_in_data(fifo_in),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(i_data_read),
    .o_out_data(fifo_out)
  );

  assign o_receive_complete = fifo_out_valid;
  assign o_pin_override = enabled;
  assign o_frame_active = (state_q != ST_IDLE);

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) o_data_buffer_location <= '0;
    else o_data_buffer_location <= fifo_out;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  disable_stops_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    !i_receiver_enable_bit |=> state_q == ST_IDLE) else $error("frame survived disable");
  pin_release_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    !i_receiver_enable_bit |-> !o_pin_override) else $error("pin not released");
  flush_empty_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    !i_receiver_enable_bit |=> !o_receive_complete) else $error("buffer not flushed");
  noise_reject_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    start_noise |=> state_q == ST_IDLE) else $error("noise accepted");
  start_accept_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    start_ok && enabled |=> state_q == ST_BITS && sample_q == $past(vote_last) + 4'h1)
    else $error("start not accepted");
  sample_range_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    i_double_speed_select && state_q == ST_BITS |-> sample_q <= SAMPLES_DOUBLE)
    else $error("sample state overran");
  frame_err_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    stop_done && enabled && !pending_q |=> pending_q && pend_fe_q != $past(majority))
    else $error("framing flag wrong");
  next_start_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    stop_done && enabled |=> state_q == ST_IDLE) else $error("late start hunt");
  rxc_level_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    push && enabled |=> o_receive_complete) else $error("rxc missing");

  ////////////////////////////////////////////////////////////////////////////
  // Frame length watch: ticks from the start edge to the last stop vote.
  // Only meaningful while the speed select stays put for the whole frame.
  logic [7:0] frame_ticks_q;
  wire [7:0] last_ext = {4'h0, last_sample};
  wire [7:0] stop_ext = {4'h0, BIT_COUNT_STOP};
  wire [7:0] vote_ext = {4'h0, vote_last};
  wire [7:0] frame_ticks_exp = (last_ext + 8'h1) * stop_ext + vote_ext - 8'h1;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      frame_ticks_q <= 8'h0;
    end else if (!enabled || state_q == ST_IDLE) begin
      frame_ticks_q <= 8'h0;
    end else if (i_sample_tick) begin
      frame_ticks_q <= frame_ticks_q + 8'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Store path in steps: last stop vote, pending slot, then the buffer
  sequence frame_end_s;
    stop_done && enabled && !pending_q && fifo_in_ready;
  endsequence

  sequence noise_seen_s;
    start_noise && enabled;
  endsequence

  sequence start_seen_s;
    new_frame && enabled;
  endsequence

  store_chain_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    frame_end_s ##1 enabled |=> o_receive_complete)
    else $error("frame not stored");

  store_data_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    frame_end_s |=> pending_q && pend_data_q == $past(shift_q))
    else $error("stored data wrong");

  ovr_clear_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    frame_end_s |=> !ovr_flag_q)
    else $error("overrun not cleared");

  noise_idle_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    noise_seen_s |=> !o_frame_active)
    else $error("noise started frame");

  start_count_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    start_seen_s |=> state_q == ST_START && sample_q == 4'h1)
    else $error("first low not sample one");

  sync_chain_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    sync2_q == $past(sync1_q))
    else $error("synchroniser skipped");

  resync_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    state_q == ST_IDLE && enabled |=> sample_q == 4'h1)
    else $error("timing not rearmed");

  vote_window_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    state_q == ST_START && vote_done |->
    sample_q == (i_double_speed_select ? VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL) + 4'h2)
    else $error("start judged off centre");

  bit_wrap_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    state_q == ST_BITS && enabled && i_sample_tick && sample_q == last_sample |=> sample_q == 4'h0)
    else $error("bit state did not wrap");

  stop_limit_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    state_q == ST_BITS |-> bitn_q <= BIT_COUNT_STOP)
    else $error("bits past first stop");

  overrun_mark_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    new_frame && enabled && pending_q && !fifo_in_ready |=> ovr_flag_q)
    else $error("overrun not flagged");

  frame_length_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    stop_done && enabled |-> frame_ticks_q == frame_ticks_exp)
    else $error("frame length wrong");

  pin_take_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    enabled |-> o_pin_override)
    else $error("pin not taken");

  disable_drop_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    !enabled |=> !pending_q)
    else $error("pending kept on disable");

  head_follow_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    $past(fifo_out_valid) |-> o_data_buffer_location == $past(fifo_out))
    else $error("head entry not shown");
endmodule
`default_nettype wire

// [src/uart_rx_pkg.sv]
/*
  Constants, types and carriers for the asynchronous serial receiver.
  Assumes a single system clock domain and a sample tick from a baud generator.
*/
// Operation
// - Clearing receiver enable stops reception at once, abandoning the current frame.
// - While disabled, the receiver releases its takeover of the serial input pin.
// - Disabling empties the buffer so receive-complete reads zero.
// - Sample at sixteen times baud, or eight times with double speed.
// - Falling edge on idle input starts detection; first low sample is one.
// - Judge start bit from samples 8,9,10 or 4,5,6 in double speed.
// - Two or more high check samples mean noise; hunt again.
// - Bit timing resynchronises on every accepted start bit.
// - Recovery steps sixteen or eight sample states per bit, numbered by state.
// - Each bit is the majority of its three centre samples.
// - Recover data bits and first stop bit only; further stop bits ignored.
// - A zero first stop bit sets the framing error for that frame.
// - Next start edge accepted right after the last stop voting sample.
// - Receive-complete is one whenever the buffer holds unread characters.
// - Error flags travel with their character; reading advances to next entry.
// - Overrun flagged when buffer full, shift register loaded, new start arrives.
package uart_rx_pkg;
  localparam int DATA_BITS = 8;
  localparam int FIFO_DEPTH = 4;
  localparam logic [3:0] SAMPLES_NORMAL = 4'hf;   // Last state index, 16 states
  localparam logic [3:0] SAMPLES_DOUBLE = 4'h7;   // Last state index, 8 states
  localparam logic [3:0] VOTE_FIRST_NORMAL = 4'h8;
  localparam logic [3:0] VOTE_FIRST_DOUBLE = 4'h4;
  localparam logic [3:0] BIT_COUNT_STOP = 4'h9;   // Start=0, data 1..8, stop=9

  typedef struct packed {
    logic overrun;
    logic frame_error;
    logic [DATA_BITS-1:0] data;
  } rx_entry_t;

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BITS} rx_state_t;
endpackage

// [src/rx_fifo.sv]
/*
  Small synchronous FIFO with valid/ready on both sides and a flush input.
  Assumes one clock; flush wins over any push or pop in that cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module rx_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  input wire logic i_clock,              // System clock
  input wire logic i_rstn,               // Async reset, active low
  input wire logic i_flush,              // Empty the FIFO
  input wire logic i_in_valid,           // Write request
  output logic o_in_ready,               // Space available
  input wire logic [WIDTH-1:0] i_in_data, // Write data
  output logic o_out_valid,              // Entry available
  input wire logic i_out_ready,          // Pop request
  output logic [WIDTH-1:0] o_out_data    // Head entry
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_q;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;
  assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data = mem_q[rd_q];

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (i_flush) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= AW'((wr_q + 1'b1) % DEPTH);
      if (pop) rd_q <= AW'((rd_q + 1'b1) % DEPTH);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// [sim/serial_tx_model.sv]
/*
  Behavioural remote transmitter: 8N1 frames, LSB first, timed on the sample tick.
  Assumes the tick is shared with the receiver and that the line idles high.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_tx_model (
  input wire logic i_clock, // System clock
  input wire logic i_tick,  // Sample tick
  output logic o_line       // Serial line, idle high
);
  initial o_line = 1'b1;

  // Each level is launched just after a tick edge and held for n ticks
  task automatic hold(input logic v, input int n);
    #2 o_line = v;
    repeat (n) @(posedge i_clock iff i_tick);
  endtask

  // A short stop length lets the next start edge come early
  task automatic send(input logic [7:0] d, input logic stop, input int s, input int stop_len);
    @(posedge i_clock iff i_tick);
    hold(1'b0, s);
    for (int i = 0; i < 8; i++) hold(d[i], s);
    hold(stop, stop_len);
    #2 o_line = 1'b1;
  endtask

  task automatic glitch(input int n);
    @(posedge i_clock iff i_tick);
    hold(1'b0, n);
    #2 o_line = 1'b1;
  endtask
endmodule
`default_nettype wire

// [sim/tb.sv]
/*
  Self-checking bench for the receiver with a queue model of its buffer.
  Assumes a tick every fourth clock and the transmitter model on the line.
*/
`timescale 1ns/1ps
`default_nettype none
module tb
  import uart_rx_pkg::*;
;
  logic clock = 1'b0, rstn = 1'b0, en = 1'b1, dbl = 1'b0, tick = 1'b0, rd = 1'b0;
  logic line, ovr_pin, rc, act, lost = 1'b0;
  logic [1:0] div = 2'h0;
  rx_entry_t dbuf;
  rx_entry_t exp_q[$];
  integer seed = 15;
  int error_cnt = 0, check_count = 0, cycles = 0, n;

  initial forever #12.5 clock = ~clock;
  always @(posedge clock) begin
    div <= div + 2'h1;
    tick <= #2 (div == 2'h3);
    cycles++;
    if (cycles == 60000) begin
      error_cnt++;
      give_verdict();
    end
  end

  uart_async_receiver_recovery uut (.i_clock(clock), .i_rstn(rstn), .i_receiver_enable_bit(en),
    .i_double_speed_select(dbl), .i_sample_tick(tick), .i_serial_input_pin(line),
    .o_pin_override(ovr_pin), .i_data_read(rd), .o_receive_complete(rc),
    .o_data_buffer_location(dbuf), .o_frame_active(act));
  serial_tx_model p (.i_clock(clock), .i_tick(tick), .o_line(line));

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
    check_count++;
    if (exp !== got) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_cycles(input int k);
    repeat (k) @(posedge clock);
    #2;
  endtask

  task automatic pulse_read();
    @(posedge clock);
    #2 rd = 1'b1;
    @(posedge clock);
    #2 rd = 1'b0;
  endtask

  // Buffer holds four entries plus one pending; later frames are lost
  task automatic tx(input logic [7:0] d, input logic stop, input int sl);
    p.send(d, stop, dbl ? 8 : 16, sl > 0 ? sl : (dbl ? 8 : 16));
    if (exp_q.size() == 5) lost = 1'b1;
    else begin
      exp_q.push_back('{lost, !stop, d});
      lost = 1'b0;
    end
  endtask

  task automatic drain();
    rx_entry_t e;
    while (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      wait_cycles(3);
      check("complete", 10'(rc), 10'h1);
      check("entry", e, dbuf);
      pulse_read();
    end
    wait_cycles(3);
    check("empty", 10'(rc), 10'h0);
  endtask

  task automatic done(input string name);
    $display("test %s done, mismatches %0d", name, error_cnt);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clock);
    #2 rstn = 1'b1;
    for (int m = 0; m < 2; m++) begin
      dbl = m[0];
      repeat (3) tx(8'($random(seed)), 1'b1, 0);
      tx(8'($random(seed)), 1'b0, 0);
      tx(8'($random(seed)), 1'b1, 0);
      drain();
      repeat (3) tx(8'($random(seed)), 1'b1, dbl ? 7 : 12);
      drain();
      // Low until just before the first check sample: all three check samples see high
      p.glitch(dbl ? 4 : 8);
      repeat (8) @(posedge clock iff tick);
      wait_cycles(1);
      check("noise", {act, rc}, 10'h0);
      tx(8'($random(seed)), 1'b1, 0);
      drain();
      done("recovery");
    end
    repeat (7) tx(8'($random(seed)), 1'b1, 0);
    drain();
    tx(8'($random(seed)), 1'b1, 0);
    drain();
    done("overrun");
    repeat (3) tx(8'($random(seed)), 1'b1, 0);
    n = 0;
    wait_cycles(3);
    while (rc === 1'b1 && n < 10) begin
      pulse_read();
      wait_cycles(2);
      n++;
    end
    check("flush reads", 10'(n), 10'h3);
    exp_q.delete();
    done("flush");
    repeat (2) tx(8'($random(seed)), 1'b1, 0);
    fork
      p.send(8'h5a, 1'b1, 8, 8);
      begin
        repeat (40) @(posedge clock iff tick);
        #2 en = 1'b0;
      end
    join
    wait_cycles(2);
    check("disabled", {ovr_pin, act, rc}, 10'h0);
    exp_q.delete();
    lost = 1'b0;
    en = 1'b1;
    wait_cycles(2);
    check("enabled", 10'(ovr_pin), 10'h1);
    tx(8'($random(seed)), 1'b1, 0);
    drain();
    done("disable");
    give_verdict();
  end
endmodule
`default_nettype wire
